// >>> pcs_coding_mode_port_crossover.sv
// How it works
// - 8b10b coding accepts only CPRI rate options 2 through 7.
// - 64b66b coding accepts only CPRI rate options 7a, 8 and 9.
// - Changing between those rate groups means switching the coding mode.
// - The 8b10b port set holds every 64b66b port; one connection serves both.
// - Disparity-function bit 15 is the electrical idle request in 64b66b.
// - Disparity-function bit 14 is the encoder bypass in 64b66b.
// - Disparity bits 13:0 and flags 7:5 form the unused 17-bit input bus.
// - Transmit flag bit 4 is the sequence-start indication in 64b66b.
// - Transmit flags 3:0 carry the four-bit sync header in 64b66b.
// - Transmit data word keeps its bit meaning in both modes.
// - Receive flag bit 7 reports decoder bypass in 64b66b.
// - Receive flags 6:0, lane 7..5 error flags and lane 4 invalid-code flag become unused outputs 13:0.
// - Lane 4 disparity fault reports a valid sync header in 64b66b.
// - Lane 3 invalid-code flag reports high bit error rate in 64b66b.
// - Lane 3 disparity fault reports block lock in 64b66b.
// - Lane 2 invalid-code flag reports receive sequence start in 64b66b.
// - Lane 2 disparity fault reports a valid received word in 64b66b.
// - Lanes 1 and 0 error flags carry the received sync header in 64b66b.
// - Receive data word keeps its bit meaning in both modes.
// - Coding select is one-hot: 0b0100 is 8b10b, 0b0010 is 64b66b.
// - In 64b66b the aligner searches a new pattern only after reset.
// Purpose: Shared fabric port crossover between 8b10b and 64b66b coding.
// Assumes: Lane-side ports are synchronous to sys_clk_in; AHB-Lite slave.
// Notes: Control 0x00 write: select[3:0], reset[4], realign[5]; read: select[3:0], reset[5]; status 0x04; rate 0x08.
//
// Design decisions made here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module pcs_coding_mode_port_crossover (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Fabric transmit side, full 8b10b port set
    input wire pcs_crossover_pkg::tx_lane_s fabric_tx_in,
    // Fabric receive side, full 8b10b port set
    output pcs_crossover_pkg::rx_lane_s fabric_rx_out,
    // Coding layer transmit side
    output pcs_crossover_pkg::tx_lane_s coder_tx_out,
    output pcs_crossover_pkg::tx_ctrl_s coder_tx_ctrl_out,
    // Coding layer receive side
    input wire logic [63:0] coder_rx_data_in,
    input wire logic [7:0] coder_rx_k_in,
    input wire logic [7:0] coder_rx_invalid_code_in,
    input wire logic [7:0] coder_rx_disparity_fault_in,
    input wire pcs_crossover_pkg::rx_ctrl_s coder_rx_ctrl_in,
    // Lane control
    output logic [3:0] lane_coding_select_out,
    output logic coding_layer_async_reset_n_out,
    output logic aligner_restart_out
);

    typedef struct packed {
        logic [3:0] coding_sel;
        logic [3:0] rate;
        logic soft_reset;
        logic realign;
        logic rate_error;
        logic data_phase;
        logic data_write;
        logic [7:0] data_addr;
        logic [31:0] rdata;
        pcs_crossover_pkg::tx_lane_s tx;
        pcs_crossover_pkg::tx_ctrl_s tx_ctrl;
        pcs_crossover_pkg::rx_lane_s rx;
    } state_s;

    state_s state_reg;
    state_s state_next;

    logic mode_64b;
    logic rate_ok;
    logic [3:0] new_rate;
    pcs_crossover_pkg::tx_ctrl_s tx_map;
    pcs_crossover_pkg::rx_lane_s rx_map;

    assign mode_64b = (state_reg.coding_sel == pcs_crossover_pkg::CODING_64B66B);

    // A rate is accepted only if the currently selected coding can carry it.
    function automatic logic rate_allowed(input logic [3:0] sel, input logic [3:0] r);
        logic ok;
        ok = 1'b0;
        if (sel == pcs_crossover_pkg::CODING_8B10B) begin
            ok = (r >= pcs_crossover_pkg::RATE_8B_MIN) && (r <= pcs_crossover_pkg::RATE_8B_MAX);
        end else if (sel == pcs_crossover_pkg::CODING_64B66B) begin
            ok = (r == pcs_crossover_pkg::RATE_7A) || (r == pcs_crossover_pkg::RATE_8) ||
                 (r == pcs_crossover_pkg::RATE_9);
        end
        return ok;
    endfunction

    // Transmit crossover: shared disparity and flag bits renamed for 64b66b.
    always_comb begin
        tx_map.elec_idle = fabric_tx_in.disp_fn[pcs_crossover_pkg::TX_IDLE_BIT];
        tx_map.bypass = fabric_tx_in.disp_fn[pcs_crossover_pkg::TX_BYPASS_BIT];
        tx_map.unused_in[1:0] = fabric_tx_in.disp_fn[13:12];
        tx_map.unused_in[5:2] = fabric_tx_in.disp_fn[11:8];
        tx_map.unused_in[7:6] = fabric_tx_in.disp_fn[7:6];
        tx_map.unused_in[11:8] = fabric_tx_in.disp_fn[5:2];
        tx_map.unused_in[12] = fabric_tx_in.disp_fn[1];
        tx_map.unused_in[13] = fabric_tx_in.disp_fn[0];
        tx_map.unused_in[15:14] = fabric_tx_in.k_flags[7:6];
        tx_map.unused_in[16] = fabric_tx_in.k_flags[5];
        tx_map.sos = fabric_tx_in.k_flags[pcs_crossover_pkg::TX_SEQUENCE_START_BIT];
        tx_map.header = fabric_tx_in.k_flags[3:0];
        if (!mode_64b) begin
            tx_map = '0;
        end
    end

    // Receive crossover: in 64b66b the error flags carry status fields.
    always_comb begin
        rx_map.data = coder_rx_data_in;
        rx_map.k_flags = coder_rx_k_in;
        rx_map.invalid_code = coder_rx_invalid_code_in;
        rx_map.disparity_fault = coder_rx_disparity_fault_in;
        if (mode_64b) begin
            rx_map.k_flags[7] = coder_rx_ctrl_in.bypass;
            rx_map.k_flags[6:0] = coder_rx_ctrl_in.unused_out[6:0];
            rx_map.invalid_code[7] = coder_rx_ctrl_in.unused_out[7];
            rx_map.disparity_fault[7] = coder_rx_ctrl_in.unused_out[8];
            rx_map.invalid_code[6] = coder_rx_ctrl_in.unused_out[9];
            rx_map.disparity_fault[6] = coder_rx_ctrl_in.unused_out[10];
            rx_map.invalid_code[5] = coder_rx_ctrl_in.unused_out[11];
            rx_map.disparity_fault[5] = coder_rx_ctrl_in.unused_out[12];
            rx_map.invalid_code[4] = coder_rx_ctrl_in.unused_out[13];
            rx_map.disparity_fault[4] = coder_rx_ctrl_in.header_valid;
            rx_map.invalid_code[3] = coder_rx_ctrl_in.high_error_rate;
            rx_map.disparity_fault[3] = coder_rx_ctrl_in.block_lock;
            rx_map.invalid_code[2] = coder_rx_ctrl_in.sos;
            rx_map.disparity_fault[2] = coder_rx_ctrl_in.word_valid;
            rx_map.invalid_code[1] = coder_rx_ctrl_in.header[3];
            rx_map.disparity_fault[1] = coder_rx_ctrl_in.header[2];
            rx_map.invalid_code[0] = coder_rx_ctrl_in.header[1];
            rx_map.disparity_fault[0] = coder_rx_ctrl_in.header[0];
        end
    end

    assign new_rate = hwdata_in[3:0];
    assign rate_ok = rate_allowed(state_reg.coding_sel, new_rate);

    always_comb begin
        state_next = state_reg;
        state_next.realign = 1'b0;
        // Both directions pass one register stage; the data word is never altered.
        state_next.tx = fabric_tx_in;
        state_next.tx_ctrl = tx_map;
        state_next.rx = rx_map;
        // Address phase capture.
        state_next.data_phase = hsel_in && hready_in && htrans_in[1];
        state_next.data_write = hwrite_in;
        state_next.data_addr = haddr_in[7:0];
        state_next.rdata = 32'h0000_0000;
        if (state_reg.data_phase && state_reg.data_write) begin
            unique case (state_reg.data_addr)
                pcs_crossover_pkg::OFS_CONTROL: begin
                    // Coding changes only while the lane is held in reset; others ignored.
                    if (state_reg.soft_reset &&
                        (hwdata_in[3:0] == pcs_crossover_pkg::CODING_8B10B ||
                         hwdata_in[3:0] == pcs_crossover_pkg::CODING_64B66B)) begin
                        state_next.coding_sel = hwdata_in[3:0];
                    end
                    state_next.soft_reset = hwdata_in[pcs_crossover_pkg::CTL_RESET_BIT];
                    // Realignment request only takes effect in 8b10b, where it pulses the restart and the reset.
                    state_next.realign = hwdata_in[pcs_crossover_pkg::CTL_REALIGN_BIT] &&
                                         !mode_64b;
                end
                pcs_crossover_pkg::OFS_RATE: begin
                    if (rate_ok) begin
                        state_next.rate = new_rate;
                        state_next.rate_error = 1'b0;
                    end else begin
                        state_next.rate_error = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        // Reads take the next-state values so a read right behind a write sees that write.
        if (hsel_in && hready_in && htrans_in[1] && !hwrite_in) begin
            unique case (haddr_in[7:0])
                pcs_crossover_pkg::OFS_CONTROL: begin
                    state_next.rdata = {26'h0, state_next.soft_reset, 1'b0,
                                        state_next.coding_sel};
                end
                pcs_crossover_pkg::OFS_STATUS: begin
                    state_next.rdata = {29'h0, state_next.rate_error,
                        (state_next.coding_sel == pcs_crossover_pkg::CODING_64B66B),
                        coder_rx_ctrl_in.block_lock};
                end
                pcs_crossover_pkg::OFS_RATE: begin
                    state_next.rdata = {28'h0, state_next.rate};
                end
                default: begin
                    state_next.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= '0;
            state_reg.coding_sel <= pcs_crossover_pkg::CODING_RESET;
            state_reg.rate <= pcs_crossover_pkg::RATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign hrdata_out = state_reg.rdata;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign fabric_rx_out = state_reg.rx;
    assign coder_tx_out = state_reg.tx;
    assign coder_tx_ctrl_out = state_reg.tx_ctrl;
    assign lane_coding_select_out = state_reg.coding_sel;
    // Driven from the system clock only, so a stopped receive clock cannot lock it.
    assign coding_layer_async_reset_n_out = !(state_reg.soft_reset || state_reg.realign);
    assign aligner_restart_out = state_reg.realign;

    sequence rate_write_s;
        state_reg.data_phase && state_reg.data_write && state_reg.data_addr == pcs_crossover_pkg::OFS_RATE;
    endsequence

    onehot_select_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        $onehot(lane_coding_select_out))
        else $error("Coding select is not one-hot.");

    rate_8b_range_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        rate_write_s and (!mode_64b && rate_ok) |=> (state_reg.rate >= 4'h2 && state_reg.rate <= 4'h7))
        else $error("8b10b rate outside 2 to 7.");

    rate_64b_set_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        rate_write_s and (mode_64b && rate_ok) |=> state_reg.rate inside {4'h8, 4'h9, 4'hA})
        else $error("64b66b rate not 7a, 8 or 9.");

    mode_in_reset_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        $changed(lane_coding_select_out) |-> !coding_layer_async_reset_n_out)
        else $error("Coding changed outside reset.");

    tx_idle_map_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        mode_64b && $stable(mode_64b) |=> coder_tx_ctrl_out.elec_idle == $past(fabric_tx_in.disp_fn[15]))
        else $error("Idle request not from bit 15.");

    tx_bypass_map_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        mode_64b && $stable(mode_64b) |=> coder_tx_ctrl_out.bypass == $past(fabric_tx_in.disp_fn[14]))
        else $error("Bypass not from bit 14.");

    tx_header_map_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        mode_64b && $stable(mode_64b) |=> coder_tx_ctrl_out.header == $past(fabric_tx_in.k_flags[3:0]) &&
        coder_tx_ctrl_out.sos == $past(fabric_tx_in.k_flags[4]))
        else $error("Header or start not from flags.");

    tx_data_pass_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        1'b1 |=> coder_tx_out.data == $past(fabric_tx_in.data))
        else $error("Transmit data altered.");

    rx_lock_map_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        mode_64b && $stable(mode_64b) |=> fabric_rx_out.disparity_fault[3] == $past(coder_rx_ctrl_in.block_lock) &&
        fabric_rx_out.invalid_code[3] == $past(coder_rx_ctrl_in.high_error_rate))
        else $error("Lock or error rate misplaced.");

    rx_valid_map_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        mode_64b && $stable(mode_64b) |=> fabric_rx_out.disparity_fault[2] == $past(coder_rx_ctrl_in.word_valid) &&
        fabric_rx_out.disparity_fault[4] == $past(coder_rx_ctrl_in.header_valid))
        else $error("Valid flags misplaced.");

    rx_data_pass_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        1'b1 |=> fabric_rx_out.data == $past(coder_rx_data_in))
        else $error("Receive data altered.");

endmodule

// >>> pcs_crossover_pkg.sv
// Purpose: Shared constants and carriers for the coding-mode port crossover.
// Assumes: One 40 MHz clock, AHB-Lite register access with 32-bit words.
// Notes: Field positions are those of the shared fabric port set.
package pcs_crossover_pkg;

    localparam logic [3:0] CODING_8B10B = 4'h4;
    localparam logic [3:0] CODING_64B66B = 4'h2;
    localparam logic [3:0] CODING_RESET = 4'h4;

    // Register byte offsets.
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_RATE = 8'h08;

    // Control register fields.
    localparam int CTL_SEL_LSB = 0;
    localparam int CTL_RESET_BIT = 4;
    localparam int CTL_REALIGN_BIT = 5;

    // Transmit shared positions.
    localparam int TX_IDLE_BIT = 15;
    localparam int TX_BYPASS_BIT = 14;
    localparam int TX_SEQUENCE_START_BIT = 4;

    // Allowed rate options per coding; index 10 stands for option 7a.
    localparam logic [3:0] RATE_8B_MIN = 4'h2;
    localparam logic [3:0] RATE_8B_MAX = 4'h7;
    localparam logic [3:0] RATE_7A = 4'hA;
    localparam logic [3:0] RATE_8 = 4'h8;
    localparam logic [3:0] RATE_9 = 4'h9;
    localparam logic [3:0] RATE_RESET = 4'h2;

    typedef struct packed {
        logic [63:0] data;
        logic [15:0] disp_fn;
        logic [7:0] k_flags;
    } tx_lane_s;

    typedef struct packed {
        logic [63:0] data;
        logic [7:0] k_flags;
        logic [7:0] invalid_code;
        logic [7:0] disparity_fault;
    } rx_lane_s;

    typedef struct packed {
        logic elec_idle;
        logic bypass;
        logic [16:0] unused_in;
        logic sos;
        logic [3:0] header;
    } tx_ctrl_s;

    typedef struct packed {
        logic bypass;
        logic [13:0] unused_out;
        logic header_valid;
        logic high_error_rate;
        logic block_lock;
        logic sos;
        logic word_valid;
        logic [3:0] header;
    } rx_ctrl_s;

endpackage

// >>> fabric_adapter_model.sv
// Purpose: Fabric adaptation logic on the far side of the shared lane port set.
// Assumes: Purely combinational; tests change its inputs just after a clock edge.
// Notes: It always drives the full 8b10b set and folds 64b66b fields into it.
`timescale 1ns/1ps
module fabric_adapter_model (
    // Mode and transmit fields from the tests
    input wire logic mode64_in,
    input wire logic [63:0] data_in,
    input wire logic [15:0] disp_raw_in,
    input wire logic [7:0] k_raw_in,
    input wire pcs_crossover_pkg::tx_ctrl_s tx_fields_in,
    // Lane port set
    output pcs_crossover_pkg::tx_lane_s fabric_tx_out,
    input wire pcs_crossover_pkg::rx_lane_s fabric_rx_in,
    // Decoded receive fields
    output pcs_crossover_pkg::rx_ctrl_s rx_fields_out
);
    always_comb begin
        fabric_tx_out.data = data_in;
        fabric_tx_out.disp_fn = disp_raw_in;
        fabric_tx_out.k_flags = k_raw_in;
        // Unused inputs are forced low so a stale 8b10b value cannot leak into 64b66b.
        if (mode64_in) begin
            fabric_tx_out.disp_fn = {tx_fields_in.elec_idle, tx_fields_in.bypass, 14'h0000};
            fabric_tx_out.k_flags = {3'h0, tx_fields_in.sos, tx_fields_in.header};
        end
    end
    always_comb begin
        rx_fields_out.bypass = fabric_rx_in.k_flags[7];
        rx_fields_out.unused_out = {fabric_rx_in.invalid_code[7], fabric_rx_in.disparity_fault[7],
            fabric_rx_in.invalid_code[6], fabric_rx_in.disparity_fault[6],
            fabric_rx_in.invalid_code[5], fabric_rx_in.disparity_fault[5],
            fabric_rx_in.invalid_code[4], fabric_rx_in.k_flags[6:0]};
        rx_fields_out.header_valid = fabric_rx_in.disparity_fault[4];
        rx_fields_out.high_error_rate = fabric_rx_in.invalid_code[3];
        rx_fields_out.block_lock = fabric_rx_in.disparity_fault[3];
        rx_fields_out.sos = fabric_rx_in.invalid_code[2];
        rx_fields_out.word_valid = fabric_rx_in.disparity_fault[2];
        rx_fields_out.header = {fabric_rx_in.invalid_code[1], fabric_rx_in.disparity_fault[1],
            fabric_rx_in.invalid_code[0], fabric_rx_in.disparity_fault[0]};
    end
endmodule

// >>> testbench.sv
// Purpose: Self-checking bench for the coding-mode port crossover.
// Assumes: Zero-wait AHB-Lite slave; lane paths registered.
// Notes: Bit order inside unused and receive header groups is open, so they get all ones or zeros.
`timescale 1ns/1ps
module testbench;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic mode64 = 1'b0;
    logic [63:0] tdata = 64'h0;
    logic [15:0] tdisp = 16'h0;
    logic [7:0] tk = 8'h0;
    pcs_crossover_pkg::tx_ctrl_s tf = '0;
    pcs_crossover_pkg::tx_lane_s ftx;
    pcs_crossover_pkg::rx_lane_s frx;
    pcs_crossover_pkg::tx_lane_s ctx;
    pcs_crossover_pkg::tx_ctrl_s cctl;
    pcs_crossover_pkg::rx_lane_s crx = '0;
    pcs_crossover_pkg::rx_ctrl_s rctl = '0;
    pcs_crossover_pkg::rx_ctrl_s rdec;
    logic [3:0] sel;
    logic lrst_n;
    logic realign;
    logic [31:0] rd;
    int fails = 0;
    int comparisons = 0;
    pcs_coding_mode_port_crossover dut (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout),
        .hresp_out(hresp), .fabric_tx_in(ftx), .fabric_rx_out(frx), .coder_tx_out(ctx),
        .coder_tx_ctrl_out(cctl), .coder_rx_data_in(crx.data), .coder_rx_k_in(crx.k_flags),
        .coder_rx_invalid_code_in(crx.invalid_code),
        .coder_rx_disparity_fault_in(crx.disparity_fault), .coder_rx_ctrl_in(rctl),
        .lane_coding_select_out(sel), .coding_layer_async_reset_n_out(lrst_n),
        .aligner_restart_out(realign));
    fabric_adapter_model partner (
        .mode64_in(mode64), .data_in(tdata), .disp_raw_in(tdisp), .k_raw_in(tk),
        .tx_fields_in(tf), .fabric_tx_out(ftx), .fabric_rx_in(frx), .rx_fields_out(rdec));
    initial forever #12.5 sys_clk_in = ~sys_clk_in;
    task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge sys_clk_in);
        while (hreadyout !== 1'b1) @(posedge sys_clk_in);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge sys_clk_in);
        while (hreadyout !== 1'b1) @(posedge sys_clk_in);
        rd = hrdata;
    endtask
    task automatic settle;
        repeat (2) @(posedge sys_clk_in);
        #1;
    endtask
    task automatic pulses(input logic [31:0] wd, input int exp);
        int na;
        int nr;
        na = 0;
        nr = 0;
        ahb(1'b1, 32'h0, wd);
        repeat (6) begin
            #1;
            na += (realign === 1'b1);
            nr += (lrst_n === 1'b0);
            @(posedge sys_clk_in);
        end
        chk(na, exp);
        chk(nr, exp);
    endtask
    // Every code 0..F is tried, so a bound off by one shows up as a wrong readback.
    task automatic rates(input logic [3:0] lo, input logic [3:0] hi, input logic [3:0] extra,
            input logic [3:0] start);
        logic [3:0] cur;
        logic ok;
        cur = start;
        for (int r = 0; r < 16; r++) begin
            ok = (r >= lo && r <= hi) || r == extra;
            if (ok) cur = r[3:0];
            ahb(1'b1, 32'h08, r);
            ahb(1'b0, 32'h08, 32'h0);
            chk(rd[3:0], cur);
            ahb(1'b0, 32'h04, 32'h0);
            chk(rd[2], !ok);
        end
    endtask
    task automatic switch_to(input logic [3:0] s, input logic [3:0] old);
        ahb(1'b1, 32'h0, 32'h10);
        settle();
        chk(lrst_n, 1'b0);
        ahb(1'b1, 32'h0, 32'h13);
        settle();
        chk(sel, old);
        ahb(1'b1, 32'h0, {27'h0, 1'b1, s});
        ahb(1'b1, 32'h0, {28'h0, s});
        settle();
        chk({sel, lrst_n}, {s, 1'b1});
    endtask
    task automatic stop_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        fails++;
        stop_test();
    end
    initial begin
        repeat (6) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        @(posedge sys_clk_in);
        ahb(1'b0, 32'h08, 32'h0);
        chk(rd[3:0], pcs_crossover_pkg::RATE_RESET);
        ahb(1'b0, 32'h04, 32'h0);
        chk(rd[2:1], 2'h0);
        ahb(1'b1, 32'h0C, 32'hFFFFFFFF);
        ahb(1'b0, 32'h0C, 32'h0);
        chk(rd, 32'h0);
        ahb(1'b1, 32'h0, 32'h2);
        settle();
        chk({sel, lrst_n}, {pcs_crossover_pkg::CODING_8B10B, 1'b1});
        tdata <= 64'h0123456789ABCDEF;
        tdisp <= 16'hC005;
        tk <= 8'h96;
        crx <= {64'hFEDCBA9876543210, 8'h81, 8'h3C, 8'hC3};
        settle();
        chk(ctx, ftx);
        chk(cctl, 24'h0);
        chk(frx, crx);
        pulses(32'h24, 1);
        rates(pcs_crossover_pkg::RATE_8B_MIN, pcs_crossover_pkg::RATE_8B_MAX,
            pcs_crossover_pkg::RATE_8B_MAX, pcs_crossover_pkg::RATE_RESET);
        switch_to(pcs_crossover_pkg::CODING_64B66B, pcs_crossover_pkg::CODING_8B10B);
        mode64 <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            tf <= (p == 0) ? 24'h80000A : 24'h400015;
            rctl <= (p == 0) ? 24'hFFFEAF : 24'h000150;
            tdata <= ~tdata;
            crx.data <= ~crx.data;
            settle();
            chk(cctl, tf);
            chk(ctx.data, tdata);
            chk(rdec, rctl);
            chk(frx.data, crx.data);
            ahb(1'b0, 32'h04, 32'h0);
            chk(rd[1:0], {1'b1, rctl.block_lock});
        end
        pulses(32'h22, 0);
        rates(pcs_crossover_pkg::RATE_8, pcs_crossover_pkg::RATE_9,
            pcs_crossover_pkg::RATE_7A, pcs_crossover_pkg::RATE_8B_MAX);
        switch_to(pcs_crossover_pkg::CODING_8B10B, pcs_crossover_pkg::CODING_64B66B);
        mode64 <= 1'b0;
        settle();
        chk(cctl, 24'h0);
        stop_test();
    end
endmodule
